// ### design/dac_update_ctrl.sv
// dual-channel dac input/dac register control with load mask and resets
`timescale 1ns/1ps
module dac_update_ctrl
  import dac_ctrl_pkg::*;
(
  // system clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // serial link
  input  wire logic              link_clk,
  input  wire logic              frame_n,
  input  wire logic              serial_data_in,
  // control pins
  input  wire logic              load_strobe_n,
  input  wire logic              hw_reset_n,
  input  wire logic              reset_level_select,
  // dac codes
  output logic      [DATA_W-1:0] dac_code_a,
  output logic      [DATA_W-1:0] dac_code_b
);

  // ==========================================================================
  // link side
  logic [FRAME_W-1:0] shift_word;

  frame_shifter u_shifter (
    .link_clk       (link_clk),
    .reset          (reset),
    .frame_n        (frame_n),
    .serial_data_in (serial_data_in),
    .shift_word     (shift_word)
  );

  // ==========================================================================
  // synchronisers
  logic       frame_n_s;
  logic       strobe_n_s;
  logic       hw_rst_n_s;
  logic       sel_s;

  sync2 #(
    .W    (2),
    .INIT (2'h3)
  ) u_sync_hi (
    .ref_clk (ref_clk),
    .reset   (reset),
    .d       ({frame_n, load_strobe_n}),
    .q       ({frame_n_s, strobe_n_s})
  );

  sync2 #(
    .W    (2),
    .INIT (2'h0)
  ) u_sync_lo (
    .ref_clk (ref_clk),
    .reset   (reset),
    .d       ({hw_reset_n, reset_level_select}),
    .q       ({hw_rst_n_s, sel_s})
  );

  // ==========================================================================
  // edge detection
  logic frame_prev;
  logic strobe_prev;
  logic next_frame_prev;
  logic next_strobe_prev;
  logic frame_done;
  logic strobe_fall;

  always_comb begin
    next_frame_prev  = frame_n_s;
    next_strobe_prev = strobe_n_s;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      frame_prev  <= 1'b1;
      strobe_prev <= 1'b1;
    end else begin
      frame_prev  <= next_frame_prev;
      strobe_prev <= next_strobe_prev;
    end
  end

  // the shift word is static once the frame has closed, so it is read here
  assign frame_done  = frame_n_s & ~frame_prev;
  assign strobe_fall = strobe_prev & ~strobe_n_s;

  // ==========================================================================
  // frame decode
  logic [CMD_W-1:0]  cmd;
  logic [DATA_W-1:0] data;
  logic [MASK_W-1:0] mask_field;
  logic [DATA_W-1:0] clear_code;
  logic              accept;

  assign cmd        = shift_word[CMD_HI:CMD_LO];
  assign data       = shift_word[DATA_HI:DATA_LO];
  assign mask_field = shift_word[MASK_HI:MASK_LO];
  assign clear_code = sel_s ? CODE_MID : CODE_ZERO;

  // ==========================================================================
  // channel registers
  state_t            state;
  state_t            next_state;
  logic [DATA_W-1:0] in_reg   [NUM_CH];
  logic [DATA_W-1:0] dac_reg  [NUM_CH];
  logic [DATA_W-1:0] next_in  [NUM_CH];
  logic [DATA_W-1:0] next_dac [NUM_CH];
  logic [MASK_W-1:0] channel_update_mask;
  logic [MASK_W-1:0] next_mask;

  assign accept = frame_done & (state == st_run) & hw_rst_n_s;

  always_comb begin
    next_state = state;
    next_in    = in_reg;
    next_dac   = dac_reg;
    next_mask  = channel_update_mask;
    unique case (state)
      st_init: begin
        // strobe and frames are ignored until hardware reset releases
        if (hw_rst_n_s) begin
          next_state = st_run;
          for (int ch = 0; ch < NUM_CH; ch++) begin
            next_in[ch]  = clear_code;
            next_dac[ch] = clear_code;
          end
        end
      end
      st_run: begin
        if (!hw_rst_n_s) begin
          for (int ch = 0; ch < NUM_CH; ch++) begin
            next_in[ch]  = clear_code;
            next_dac[ch] = clear_code;
          end
        end else begin
          for (int ch = 0; ch < NUM_CH; ch++) begin
            if (strobe_fall && !channel_update_mask[CH_MASK_BIT[ch]]) begin
              next_dac[ch] = in_reg[ch];
            end
          end
          if (frame_done) begin
            case (cmd)
              CMD_WRITE_INPUT: begin
                for (int ch = 0; ch < NUM_CH; ch++) begin
                  if (shift_word[CH_ADDR_BIT[ch]]) begin
                    next_in[ch] = data;
                    // a low strobe level bypasses the mask
                    if (!strobe_n_s) begin
                      next_dac[ch] = data;
                    end
                  end
                end
              end
              CMD_UPDATE_DAC: begin
                for (int ch = 0; ch < NUM_CH; ch++) begin
                  if (shift_word[CH_ADDR_BIT[ch]]) begin
                    next_dac[ch] = in_reg[ch];
                  end
                end
              end
              CMD_WRITE_UPDATE: begin
                for (int ch = 0; ch < NUM_CH; ch++) begin
                  if (shift_word[CH_ADDR_BIT[ch]]) begin
                    next_in[ch]  = data;
                    next_dac[ch] = data;
                  end
                end
              end
              CMD_LOAD_MASK: begin
                next_mask = mask_field;
              end
              CMD_SOFT_RESET: begin
                next_mask = MASK_RESET;
                for (int ch = 0; ch < NUM_CH; ch++) begin
                  next_in[ch]  = clear_code;
                  next_dac[ch] = clear_code;
                end
              end
              default: begin
                next_mask = channel_update_mask;
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state               <= st_init;
      channel_update_mask <= MASK_RESET;
      for (int ch = 0; ch < NUM_CH; ch++) begin
        in_reg[ch]  <= CODE_ZERO;
        dac_reg[ch] <= CODE_ZERO;
      end
    end else begin
      state               <= next_state;
      channel_update_mask <= next_mask;
      in_reg              <= next_in;
      dac_reg             <= next_dac;
    end
  end

  assign dac_code_a = dac_reg[0];
  assign dac_code_b = dac_reg[1];

  // ==========================================================================
  // assertions
  property p_mask_load;
    @(posedge ref_clk) disable iff (reset)
      accept && (cmd == CMD_LOAD_MASK)
      |=> channel_update_mask == $past(mask_field);
  endproperty
  a_mask_load: assert property (p_mask_load)
    else $error("mask not loaded from frame");

  property p_mask_default;
    @(posedge ref_clk) disable iff (reset)
      (state == st_init) |-> (channel_update_mask == MASK_RESET);
  endproperty
  a_mask_default: assert property (p_mask_default)
    else $error("mask not at default before init");

  property p_masked_ignore;
    @(posedge ref_clk) disable iff (reset)
      channel_update_mask[CH_MASK_BIT[1]] && strobe_fall && !frame_done && hw_rst_n_s
      |=> dac_reg[1] == $past(dac_reg[1]);
  endproperty
  a_masked_ignore: assert property (p_masked_ignore)
    else $error("masked channel followed strobe");

  property p_write_input_hold;
    @(posedge ref_clk) disable iff (reset)
      accept && (cmd == CMD_WRITE_INPUT) && shift_word[CH_ADDR_BIT[0]] && strobe_n_s
      |=> (in_reg[0] == $past(data)) && (dac_reg[0] == $past(dac_reg[0]));
  endproperty
  a_write_input_hold: assert property (p_write_input_hold)
    else $error("input write with strobe high misbehaved");

  property p_update_dac;
    @(posedge ref_clk) disable iff (reset)
      accept && (cmd == CMD_UPDATE_DAC) && shift_word[CH_ADDR_BIT[1]]
      |=> (dac_reg[1] == $past(in_reg[1])) && (in_reg[1] == $past(in_reg[1]));
  endproperty
  a_update_dac: assert property (p_update_dac)
    else $error("dac not loaded from input register");

  property p_write_update;
    @(posedge ref_clk) disable iff (reset)
      accept && (cmd == CMD_WRITE_UPDATE) && shift_word[CH_ADDR_BIT[0]]
      |=> (dac_reg[0] == $past(data)) && (in_reg[0] == $past(data));
  endproperty
  a_write_update: assert property (p_write_update)
    else $error("write and update did not reach both registers");

  property p_strobe_edge;
    @(posedge ref_clk) disable iff (reset)
      (state == st_run) && hw_rst_n_s && $fell(strobe_n_s) && !frame_done
      && !channel_update_mask[CH_MASK_BIT[0]]
      |=> dac_reg[0] == $past(in_reg[0]);
  endproperty
  a_strobe_edge: assert property (p_strobe_edge)
    else $error("strobe edge did not transfer input register");

  property p_strobe_edge_b;
    @(posedge ref_clk) disable iff (reset)
      (state == st_run) && hw_rst_n_s && strobe_fall && !frame_done
      && !channel_update_mask[CH_MASK_BIT[1]]
      |=> dac_reg[1] == $past(in_reg[1]);
  endproperty
  a_strobe_edge_b: assert property (p_strobe_edge_b)
    else $error("strobe edge did not transfer channel b input register");

  property p_low_strobe_bypass;
    @(posedge ref_clk) disable iff (reset)
      accept && (cmd == CMD_WRITE_INPUT) && shift_word[CH_ADDR_BIT[1]] && !strobe_n_s
      |=> dac_reg[1] == $past(data);
  endproperty
  a_low_strobe_bypass: assert property (p_low_strobe_bypass)
    else $error("low strobe write did not update dac");

  property p_hw_clear;
    @(posedge ref_clk) disable iff (reset)
      (state == st_run) && !hw_rst_n_s
      |=> (dac_reg[0] == $past(clear_code)) && (dac_reg[1] == $past(clear_code));
  endproperty
  a_hw_clear: assert property (p_hw_clear)
    else $error("hardware reset did not clear outputs");

  property p_soft_reset;
    @(posedge ref_clk) disable iff (reset)
      accept && (cmd == CMD_SOFT_RESET)
      |=> (dac_reg[0] == $past(clear_code)) && (channel_update_mask == MASK_RESET);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("software reset did not restore power-on code");

  property p_init_wait;
    @(posedge ref_clk) disable iff (reset)
      (state == st_init) && !hw_rst_n_s
      |=> (state == st_init) && $stable(dac_reg[0]) && $stable(dac_reg[1]);
  endproperty
  a_init_wait: assert property (p_init_wait)
    else $error("initialisation ran during hardware reset");

  property p_powerup_code;
    @(posedge ref_clk) disable iff (reset)
      (state == st_init) && hw_rst_n_s
      |=> (state == st_run) && (dac_reg[1] == $past(clear_code));
  endproperty
  a_powerup_code: assert property (p_powerup_code)
    else $error("power-up code wrong");

  property p_hold_idle;
    @(posedge ref_clk) disable iff (reset)
      (state == st_run) && hw_rst_n_s && !frame_done && !strobe_fall
      |=> $stable(dac_reg[0]) && $stable(dac_reg[1]);
  endproperty
  a_hold_idle: assert property (p_hold_idle)
    else $error("dac changed without cause");

endmodule

// ### design/dac_ctrl_pkg.sv
// shared constants and types of the dual-channel dac update controller
package dac_ctrl_pkg;

  // ==========================================================================
  // frame layout
  localparam int FRAME_W    = 24;
  localparam int CMD_W      = 4;
  localparam int CMD_HI     = 23;
  localparam int CMD_LO     = 20;
  localparam int DATA_W     = 16;
  localparam int DATA_HI    = 15;
  localparam int DATA_LO    = 0;
  localparam int MASK_W     = 4;
  localparam int MASK_HI    = 3;
  localparam int MASK_LO    = 0;

  // ==========================================================================
  // channels: index 0 is channel a, index 1 is channel b
  localparam int NUM_CH                = 2;
  localparam int CH_ADDR_BIT [NUM_CH]  = '{16, 19};
  localparam int CH_MASK_BIT [NUM_CH]  = '{0, 3};

  // ==========================================================================
  // command codes
  localparam logic [CMD_W-1:0] CMD_WRITE_INPUT  = 4'h1;
  localparam logic [CMD_W-1:0] CMD_UPDATE_DAC   = 4'h2;
  localparam logic [CMD_W-1:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [CMD_W-1:0] CMD_LOAD_MASK    = 4'h5;
  localparam logic [CMD_W-1:0] CMD_SOFT_RESET   = 4'h6;

  // ==========================================================================
  // reset values
  localparam logic [DATA_W-1:0] CODE_ZERO     = 16'h0000;
  localparam logic [DATA_W-1:0] CODE_MID      = 16'h8000;
  localparam logic [MASK_W-1:0] MASK_RESET    = 4'h0;
  localparam logic [FRAME_W-1:0] SHIFT_RESET  = 24'h000000;

  // ==========================================================================
  // power-up sequencer states
  typedef enum logic [1:0] {
    st_init = 2'b01,
    st_run  = 2'b10
  } state_t;

endpackage

// ### design/sync2.sv
// two-flop synchroniser for a group of independent level inputs
`timescale 1ns/1ps
module sync2 #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ==========================================================================
  // stages
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule

// ### design/frame_shifter.sv
// serial input shift register running on the link clock
`timescale 1ns/1ps
module frame_shifter
  import dac_ctrl_pkg::*;
(
  // link clock and reset
  input  wire logic               link_clk,
  input  wire logic               reset,
  // serial link
  input  wire logic               frame_n,
  input  wire logic               serial_data_in,
  // shifted word
  output logic      [FRAME_W-1:0] shift_word
);

  // ==========================================================================
  // shifting only while the frame is open
  logic [FRAME_W-1:0] next_shift_word;

  always_comb begin
    next_shift_word = shift_word;
    if (!frame_n) begin
      next_shift_word = {shift_word[FRAME_W-2:0], serial_data_in};
    end
  end

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      shift_word <= SHIFT_RESET;
    end else begin
      shift_word <= next_shift_word;
    end
  end

endmodule

// ### tb/spi_host_model.sv
// behavioural serial host that sends one 24-bit frame per request
`timescale 1ns/1ps
module spi_host_model
  import dac_ctrl_pkg::*;
(
  // request side
  input  wire logic               ref_clk,
  input  wire logic               req,
  input  wire logic [FRAME_W-1:0] word,
  output logic                    busy,
  // serial link
  output logic                    link_clk,
  output logic                    frame_n,
  output logic                    serial_data_in
);
  logic [FRAME_W-1:0] hold;

  // ==========================================================================
  // frame generator: link clock runs only inside frames
  initial begin
    busy           = 1'b0;
    link_clk       = 1'b0;
    frame_n        = 1'b1;
    serial_data_in = 1'b0;
    forever begin
      @(posedge ref_clk iff req);
      hold = word;
      busy <= 1'b1;
      #37;
      frame_n = 1'b0;
      for (int i = FRAME_W - 1; i >= 0; i--) begin
        serial_data_in = hold[i];
        #80 link_clk = 1'b1;
        #80 link_clk = 1'b0;
      end
      #80 frame_n = 1'b1;
      serial_data_in = ~serial_data_in;
      repeat (8) @(posedge ref_clk);
      busy <= 1'b0;
    end
  end
endmodule

// ### tb/dac_update_mask_and_reset_control_tb_top.sv
// self-checking bench of the dac update controller
`timescale 1ns/1ps
module dac_update_mask_and_reset_control_tb_top;
  import dac_ctrl_pkg::*;

  // ==========================================================================
  // signals and expected state
  localparam logic [CMD_W-1:0] CMDS [5] = '{CMD_WRITE_INPUT, CMD_UPDATE_DAC,
                                            CMD_WRITE_UPDATE, CMD_LOAD_MASK, CMD_SOFT_RESET};
  logic               ref_clk            = 1'b0;
  logic               reset              = 1'b1;
  logic               load_strobe_n      = 1'b1;
  logic               hw_reset_n         = 1'b1;
  logic               reset_level_select = 1'b0;
  logic               req                = 1'b0;
  logic [FRAME_W-1:0] word               = '0;
  logic               busy;
  logic               link_clk;
  logic               frame_n;
  logic               serial_data_in;
  logic [DATA_W-1:0]  dac_code_a;
  logic [DATA_W-1:0]  dac_code_b;
  logic [DATA_W-1:0]  e_in [NUM_CH];
  logic [DATA_W-1:0]  e_dac [NUM_CH];
  logic [MASK_W-1:0]  e_mask;
  logic [31:0]        seed               = 32'h00009d9b;
  int                 n_errors           = 0;
  int                 n_checks           = 0;

  always #5 ref_clk = ~ref_clk;

  dac_update_ctrl dut (
    .ref_clk            (ref_clk),
    .reset              (reset),
    .link_clk           (link_clk),
    .frame_n            (frame_n),
    .serial_data_in     (serial_data_in),
    .load_strobe_n      (load_strobe_n),
    .hw_reset_n         (hw_reset_n),
    .reset_level_select (reset_level_select),
    .dac_code_a         (dac_code_a),
    .dac_code_b         (dac_code_b)
  );

  spi_host_model host (
    .ref_clk        (ref_clk),
    .req            (req),
    .word           (word),
    .busy           (busy),
    .link_clk       (link_clk),
    .frame_n        (frame_n),
    .serial_data_in (serial_data_in)
  );

  // ==========================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [DATA_W-1:0] clr_code(input logic sel);
    return sel ? CODE_MID : CODE_ZERO;
  endfunction

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic clear_expect(input logic [DATA_W-1:0] v);
    for (int ch = 0; ch < NUM_CH; ch++) begin
      e_in[ch]  = v;
      e_dac[ch] = v;
    end
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_dacs();
    chk(dac_code_a, e_dac[0]);
    chk(dac_code_b, e_dac[1]);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one frame through the host; take says whether the device should act on it
  task automatic frame(input logic [FRAME_W-1:0] w, input logic take);
    int               t;
    logic [CMD_W-1:0] c;
    c = w[CMD_HI:CMD_LO];
    @(posedge ref_clk);
    word <= w;
    req  <= 1'b1;
    @(posedge ref_clk);
    req <= 1'b0;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (busy !== 1'b0 && t < 2000);
    if (t >= 2000) begin
      n_errors++;
      complete_run();
    end
    if (!take) return;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (c == CMD_SOFT_RESET) begin
        e_in[ch]  = clr_code(reset_level_select);
        e_dac[ch] = e_in[ch];
      end else if (w[CH_ADDR_BIT[ch]]) begin
        if (c == CMD_UPDATE_DAC) e_dac[ch] = e_in[ch];
        if (c == CMD_WRITE_UPDATE) e_dac[ch] = w[DATA_HI:DATA_LO];
        if (c == CMD_WRITE_INPUT && !load_strobe_n) e_dac[ch] = w[DATA_HI:DATA_LO];
        if (c == CMD_WRITE_INPUT || c == CMD_WRITE_UPDATE) e_in[ch] = w[DATA_HI:DATA_LO];
      end
    end
    if (c == CMD_LOAD_MASK) e_mask = w[MASK_HI:MASK_LO];
    if (c == CMD_SOFT_RESET) e_mask = MASK_RESET;
  endtask

  task automatic set_strobe(input logic v);
    logic fall;
    fall = load_strobe_n && !v;
    @(posedge ref_clk);
    load_strobe_n <= v;
    cycles(6);
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (fall && hw_reset_n && !e_mask[CH_MASK_BIT[ch]]) e_dac[ch] = e_in[ch];
    end
  endtask

  // ==========================================================================
  // tests
  initial begin
    logic [31:0]        r;
    logic [CMD_W-1:0]   c;
    logic [FRAME_W-1:0] w;
    e_mask = MASK_RESET;
    cycles(12);
    reset <= 1'b0;
    cycles(10);
    clear_expect(CODE_ZERO);
    check_dacs();
    $display("test power_up done");

    for (int i = 0; i < 24; i++) begin
      r = rnd();
      c = (i < 5) ? CMDS[i] : CMDS[int'(r[31:29]) % 5];
      w = {c, r[19:0]};
      if (c == CMD_LOAD_MASK) w[2:1] = 2'b00;
      @(posedge ref_clk);
      reset_level_select <= r[28];
      set_strobe(r[27]);
      frame(w, 1'b1);
      check_dacs();
    end
    $display("test random_commands done");

    set_strobe(1'b1);
    frame({CMD_LOAD_MASK, 20'h00008}, 1'b1);
    frame({CMD_WRITE_INPUT, 4'h9, 16'ha5a5}, 1'b1);
    check_dacs();
    set_strobe(1'b0);
    check_dacs();
    set_strobe(1'b1);
    $display("test mask_corner done");

    @(posedge ref_clk);
    hw_reset_n <= 1'b0;
    cycles(6);
    clear_expect(clr_code(reset_level_select));
    check_dacs();
    frame({CMD_WRITE_UPDATE, 4'h9, 16'h1234}, 1'b0);
    set_strobe(1'b0);
    set_strobe(1'b1);
    check_dacs();
    @(posedge ref_clk);
    hw_reset_n <= 1'b1;
    cycles(6);
    set_strobe(1'b0);
    set_strobe(1'b1);
    check_dacs();
    $display("test hw_reset done");

    @(posedge ref_clk);
    reset              <= 1'b1;
    hw_reset_n         <= 1'b0;
    reset_level_select <= 1'b1;
    cycles(12);
    reset <= 1'b0;
    cycles(10);
    clear_expect(CODE_ZERO);
    e_mask = MASK_RESET;
    check_dacs();
    set_strobe(1'b0);
    set_strobe(1'b1);
    frame({CMD_WRITE_UPDATE, 4'h9, 16'h4321}, 1'b0);
    check_dacs();
    @(posedge ref_clk);
    hw_reset_n <= 1'b1;
    cycles(6);
    clear_expect(CODE_MID);
    check_dacs();
    frame({CMD_WRITE_INPUT, 4'h9, 16'h0ff1}, 1'b1);
    check_dacs();
    set_strobe(1'b0);
    check_dacs();
    set_strobe(1'b1);
    $display("test power_up_held done");
    complete_run();
  end

  initial begin
    #400000;
    n_errors++;
    complete_run();
  end
endmodule
